// *** mcs_pkg.sv ***
// shared constants and types for the module control/status block
package mcs_pkg;
  // 2-wire management address, 7-bit form of the 8-bit A2h
  localparam logic [6:0] MCS_DEV_ADDR     = 7'h51;
  localparam logic [7:0] MCS_RX_SOFT_OFF  = 8'h6e;
  localparam logic [7:0] MCS_TX_SOFT_OFF  = 8'h76;
  localparam int         MCS_SEL_BIT      = 3;
  localparam logic       MCS_SEL_RESET    = 1'b0;
  localparam logic [3:0] MCS_BYTE_BITS    = 4'h8;
  localparam logic [7:0] MCS_UNMAPPED_VAL = 8'h00;

  typedef enum logic [8:0] {
    MCS_ST_IDLE = 9'h001,
    MCS_ST_ADDR = 9'h002,
    MCS_ST_AACK = 9'h004,
    MCS_ST_OFFS = 9'h008,
    MCS_ST_OACK = 9'h010,
    MCS_ST_WR   = 9'h020,
    MCS_ST_WACK = 9'h040,
    MCS_ST_RD   = 9'h080,
    MCS_ST_RACK = 9'h100
  } mcs_state_t;
endpackage : mcs_pkg

// *** mcs_twi_slave.sv ***
// 2-wire serial management slave, oversampled on mclk
`timescale 1ns/1ns
`default_nettype none
module mcs_twi_slave (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // 2-wire pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // register side
  output logic            wr_en,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);
  logic [1:0]        scl_a_q, sda_a_q;
  logic              scl_b_q, sda_b_q;
  logic              scl_p_q, sda_p_q;
  mcs_pkg::mcs_state_t state_q;
  logic [7:0]        sh_q;
  logic [3:0]        cnt_q;
  logic [7:0]        ptr_q;
  logic              rw_q;
  logic              nack_q;
  logic              wr_q;
  logic              scl_rise, scl_fall, start_det, stop_det;

  // three-stage synchronisers, then one more stage for edge detection
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_a_q <= 2'h3;
      sda_a_q <= 2'h3;
      scl_b_q <= 1'b1;
      sda_b_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce) begin
      scl_a_q <= {scl_a_q[0], scl_i};
      sda_a_q <= {sda_a_q[0], sda_i};
      scl_b_q <= scl_a_q[1];
      sda_b_q <= sda_a_q[1];
      scl_p_q <= scl_b_q;
      sda_p_q <= sda_b_q;
    end
  end

  assign scl_rise  = ce & scl_b_q & ~scl_p_q;
  assign scl_fall  = ce & ~scl_b_q & scl_p_q;
  assign start_det = ce & scl_b_q & scl_p_q & ~sda_b_q & sda_p_q;
  assign stop_det  = ce & scl_b_q & scl_p_q & sda_b_q & ~sda_p_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= mcs_pkg::MCS_ST_IDLE;
      sh_q    <= 8'h00;
      cnt_q   <= 4'h0;
      ptr_q   <= 8'h00;
      rw_q    <= 1'b0;
      nack_q  <= 1'b0;
      wr_q    <= 1'b0;
    end else if (ce) begin
      wr_q <= 1'b0;
      if (start_det) begin
        state_q <= mcs_pkg::MCS_ST_ADDR;
        cnt_q   <= 4'h0;
      end else if (stop_det) begin
        state_q <= mcs_pkg::MCS_ST_IDLE;
      end else begin
        unique case (state_q)
          mcs_pkg::MCS_ST_IDLE: ;
          mcs_pkg::MCS_ST_ADDR, mcs_pkg::MCS_ST_OFFS, mcs_pkg::MCS_ST_WR: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_b_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == mcs_pkg::MCS_BYTE_BITS) begin
              cnt_q <= 4'h0;
              if (state_q == mcs_pkg::MCS_ST_ADDR) begin
                // only the management device address is answered
                if (sh_q[7:1] == mcs_pkg::MCS_DEV_ADDR) begin // RL10
                  state_q <= mcs_pkg::MCS_ST_AACK;
                  rw_q    <= sh_q[0];
                end else begin
                  state_q <= mcs_pkg::MCS_ST_IDLE;
                end
              end else if (state_q == mcs_pkg::MCS_ST_OFFS) begin
                state_q <= mcs_pkg::MCS_ST_OACK;
                ptr_q   <= sh_q;
              end else begin
                state_q <= mcs_pkg::MCS_ST_WACK;
                wr_q    <= 1'b1;
              end
            end
          end
          mcs_pkg::MCS_ST_AACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                state_q <= mcs_pkg::MCS_ST_RD;
                sh_q    <= rd_data;
              end else begin
                state_q <= mcs_pkg::MCS_ST_OFFS;
              end
            end
          end
          mcs_pkg::MCS_ST_OACK: if (scl_fall) state_q <= mcs_pkg::MCS_ST_WR;
          mcs_pkg::MCS_ST_WACK: begin
            if (scl_fall) begin
              state_q <= mcs_pkg::MCS_ST_WR;
              ptr_q   <= ptr_q + 8'h01;
            end
          end
          mcs_pkg::MCS_ST_RD: begin
            if (scl_fall) begin
              if (cnt_q == mcs_pkg::MCS_BYTE_BITS - 4'h1) begin
                state_q <= mcs_pkg::MCS_ST_RACK;
                cnt_q   <= 4'h0;
                ptr_q   <= ptr_q + 8'h01;
              end else begin
                sh_q  <= {sh_q[6:0], 1'b0};
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          mcs_pkg::MCS_ST_RACK: begin
            if (scl_rise) begin
              nack_q <= sda_b_q;
            end else if (scl_fall) begin
              // a nack from the host ends the read burst
              if (nack_q) begin
                state_q <= mcs_pkg::MCS_ST_IDLE;
              end else begin
                state_q <= mcs_pkg::MCS_ST_RD;
                sh_q    <= rd_data;
              end
            end
          end
        endcase
      end
    end
  end

  // open drain: only ever pull low
  assign sda_o   = 1'b0;
  assign sda_oe  = (state_q == mcs_pkg::MCS_ST_AACK) | (state_q == mcs_pkg::MCS_ST_OACK) |
                   (state_q == mcs_pkg::MCS_ST_WACK) | ((state_q == mcs_pkg::MCS_ST_RD) & ~sh_q[7]);
  assign wr_en   = wr_q;
  assign wr_addr = ptr_q;
  assign wr_data = sh_q;
  assign rd_addr = ptr_q;
endmodule : mcs_twi_slave
`default_nettype wire

// *** mcs_top.sv ***
// low-speed control and status logic of the pluggable transceiver module
`timescale 1ns/1ns
`default_nettype none
// What this block does
// RL1 - transmitter fault raises fault output high
// RL2 - disable high or floating turns transmitter off
// RL3 - disable input also clears reported fault
// RL4 - module-absent tied low while module present
// RL5 - low optical input raises signal-lost output
// RL6 - rx retimer bypass only when pin, bit zero
// RL7 - tx retimer bypass only when pin, bit zero
// RL8 - soft select bits default to zero
// RL9 - undriven hard select pins read zero
// RL10 - management bits reached at 2-wire address A2h
// RL11 - fault latched until disable pulsed, then re-evaluated
module mcs_top (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic ce,
  // host control pins
  input  wire logic tx_disable,
  input  wire logic rx_retimer_select_pin,
  input  wire logic tx_retimer_select_pin,
  // module-side conditions
  input  wire logic laser_fault_cond,
  input  wire logic rx_power_low,
  // host status pins
  output logic      tx_fault,
  output logic      rx_signal_lost_flag,
  output logic      module_absent_flag,
  // 2-wire management pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // module internals
  output logic      tx_laser_on,
  output logic      rx_retimer_engaged,
  output logic      tx_retimer_engaged
);
  localparam int PIN_N = 5;

  logic [PIN_N-1:0] pin_a_q;
  logic [PIN_N-1:0] pin_b_q;
  logic             dis_prev_q;
  logic             fault_q;
  logic             los_q;
  logic             rx_bit_q;
  logic             tx_bit_q;
  logic             wr_en;
  logic [7:0]       wr_addr;
  logic [7:0]       wr_data;
  logic [7:0]       rd_addr;
  logic [7:0]       rd_data;
  logic             dis_s, rx_pin_s, tx_pin_s, fault_s, low_s;
  logic             dis_release;
  logic             wr_sel_bit;

  // reads of a soft select byte: only the select bit is live
  function automatic logic [7:0] mcs_read_byte(input logic [7:0] addr, input logic rx_b, input logic tx_b);
    logic [7:0] v;
    v = mcs_pkg::MCS_UNMAPPED_VAL;
    if (addr == mcs_pkg::MCS_RX_SOFT_OFF) v[mcs_pkg::MCS_SEL_BIT] = rx_b;
    if (addr == mcs_pkg::MCS_TX_SOFT_OFF) v[mcs_pkg::MCS_SEL_BIT] = tx_b;
    return v;
  endfunction : mcs_read_byte

  // pin synchronisers; disable and low power reset high, so the laser
  // stays dark and no light is reported in the first cycles after reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_a_q <= 5'h11;
      pin_b_q <= 5'h11;
    end else if (ce) begin
      pin_a_q <= {rx_power_low, laser_fault_cond, tx_retimer_select_pin, rx_retimer_select_pin, tx_disable};
      pin_b_q <= pin_a_q;
    end
  end

  assign dis_s    = pin_b_q[0];
  assign rx_pin_s = pin_b_q[1];
  assign tx_pin_s = pin_b_q[2];
  assign fault_s  = pin_b_q[3];
  assign low_s    = pin_b_q[4];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dis_prev_q <= 1'b1;
    end else if (ce) begin
      dis_prev_q <= dis_s;
    end
  end

  assign dis_release = dis_prev_q & ~dis_s;

  // fault latch: a live condition wins over the release clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fault_q <= 1'b0;
    end else if (ce) begin
      if (fault_s) begin
        fault_q <= 1'b1; // RL1
      end else if (dis_release) begin
        fault_q <= 1'b0; // RL3 RL11
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      los_q <= 1'b1;
    end else if (ce) begin
      los_q <= low_s; // RL5
    end
  end

  // soft select bits; other bits of the bytes are not stored
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_bit_q <= mcs_pkg::MCS_SEL_RESET; // RL8
      tx_bit_q <= mcs_pkg::MCS_SEL_RESET; // RL8
    end else if (ce && wr_en) begin
      if (wr_addr == mcs_pkg::MCS_RX_SOFT_OFF) rx_bit_q <= wr_sel_bit;
      if (wr_addr == mcs_pkg::MCS_TX_SOFT_OFF) tx_bit_q <= wr_sel_bit;
    end
  end

  // written select bit, shared by both soft bytes
  assign wr_sel_bit = wr_data[mcs_pkg::MCS_SEL_BIT];
  assign rd_data    = mcs_read_byte(rd_addr, rx_bit_q, tx_bit_q);

  mcs_twi_slave u_twi (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .ce      (ce),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .sda_o   (sda_o),
    .sda_oe  (sda_oe),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // an open disable pin is pulled high outside, so it reads as off
  assign tx_laser_on         = ~dis_s; // RL2
  assign tx_fault            = fault_q;
  assign rx_signal_lost_flag = los_q;
  // strapped to module ground; the host pull-up shows absence
  assign module_absent_flag  = 1'b0; // RL4
  // an undriven hard pin is pulled to ground outside, reading as bypass
  assign rx_retimer_engaged  = rx_pin_s | rx_bit_q; // RL6 RL9
  assign tx_retimer_engaged  = tx_pin_s | tx_bit_q; // RL7 RL9

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_fault_raise: assert property (ce && laser_fault_cond ##1 ce [*2] |=> tx_fault) // RL1
    else $error("fault condition did not raise tx_fault");
  a_laser_off: assert property (ce && tx_disable ##1 ce |=> !tx_laser_on) // RL2
    else $error("laser on while disable high");
  a_fault_clear: assert property (tx_fault && ce && dis_release && !fault_s |=> !tx_fault) // RL3
    else $error("disable release did not clear fault");
  a_fault_latch: assert property (tx_fault && !(ce && dis_release) |=> tx_fault) // RL11
    else $error("fault dropped without disable pulse");
  a_absent_low: assert property (module_absent_flag == 1'b0) // RL4
    else $error("module absent flag high");
  a_los_follow: assert property (ce && rx_power_low ##1 ce [*2] |=> rx_signal_lost_flag) // RL5
    else $error("loss of signal not flagged");
  a_rx_bypass: assert property (!rx_pin_s && !rx_bit_q |-> !rx_retimer_engaged) // RL6
    else $error("rx retimer engaged in bypass case");
  a_tx_bypass: assert property (!tx_pin_s && !tx_bit_q |-> !tx_retimer_engaged) // RL7
    else $error("tx retimer engaged in bypass case");
  a_soft_hold: assert property (!(ce && wr_en) |=> $stable(rx_bit_q) && $stable(tx_bit_q)) // RL8
    else $error("soft select bit changed without write");

  // light and signal-lost follow their pins back as well
  a_laser_on: assert property (ce && !tx_disable ##1 ce |=> tx_laser_on)
    else $error("laser dark with disable low");
  a_los_clear: assert property (ce && !rx_power_low ##1 ce [*2] |=> !rx_signal_lost_flag) // RL5
    else $error("loss of signal held with light present");
  // the fault only rises from a live condition, and a release
  // while the condition persists must leave it set
  a_fault_no_spur: assert property (!tx_fault && !(ce && fault_s) |=> !tx_fault) // RL1
    else $error("fault raised without a condition");
  a_fault_recheck: assert property (ce && dis_release && fault_s |=> tx_fault) // RL11
    else $error("fault cleared while condition present");

  // any select set engages the retimer
  a_rx_engage: assert property (rx_pin_s || rx_bit_q |-> rx_retimer_engaged) // RL6
    else $error("rx retimer bypassed with a select set");
  a_tx_engage: assert property (tx_pin_s || tx_bit_q |-> tx_retimer_engaged) // RL7
    else $error("tx retimer bypassed with a select set");

  // soft bits: zero out of reset, then the written select bit
  a_soft_default: assert property ($rose(rst_b) |-> !rx_bit_q && !tx_bit_q) // RL8
    else $error("soft select bit not zero after reset");
  a_rx_soft_write: assert property (ce && wr_en && wr_addr == mcs_pkg::MCS_RX_SOFT_OFF // RL6
    |=> rx_bit_q == $past(wr_sel_bit))
    else $error("rx soft select bit not written");
  a_tx_soft_write: assert property (ce && wr_en && wr_addr == mcs_pkg::MCS_TX_SOFT_OFF // RL7
    |=> tx_bit_q == $past(wr_sel_bit))
    else $error("tx soft select bit not written");
  a_read_unmapped: assert property (rd_addr != mcs_pkg::MCS_RX_SOFT_OFF && rd_addr != mcs_pkg::MCS_TX_SOFT_OFF // RL10
    |-> rd_data == mcs_pkg::MCS_UNMAPPED_VAL)
    else $error("unmapped management byte not zero");

  // a low enable must freeze every status and select flop
  a_ce_freeze: assert property (!ce |=> $stable(fault_q) && $stable(los_q) && $stable(rx_bit_q) && $stable(tx_bit_q))
    else $error("state moved while clock enable low");

  c_fault_cycle: cover property (tx_fault ##[1:50] !tx_fault);
  c_rx_soft_on: cover property ($rose(rx_bit_q) && !rx_pin_s);
  c_tx_engaged: cover property ($rose(tx_retimer_engaged));
  c_los_drop: cover property ($fell(rx_signal_lost_flag));
  c_ce_frozen: cover property (!ce ##1 !ce);
endmodule : mcs_top
`default_nettype wire

// *** mcs_host_model.sv ***
// host board model: bit-level 2-wire master
`timescale 1ns/1ns
`default_nettype none
module mcs_host_model (
  // clock
  input  wire logic mclk,
  // 2-wire wires
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wt
  // six cycles per phase keeps clear of the device's sync delay
  task automatic phase(input logic s, input logic d);
    scl = s;
    sda_low = d;
    wt(6);
  endtask : phase
  // also serves as repeated start; scl only moves with sda steady
  task automatic start();
    phase(1'b0, 1'b0);
    phase(1'b1, 1'b0);
    phase(1'b1, 1'b1);
    phase(1'b0, 1'b1);
  endtask : start
  task automatic stop();
    phase(1'b0, 1'b1);
    phase(1'b1, 1'b1);
    phase(1'b1, 1'b0);
  endtask : stop
  task automatic bit_x(input logic b, output logic r);
    phase(1'b0, ~b);
    phase(1'b1, ~b);
    r = sda_line;
    phase(1'b0, ~b);
  endtask : bit_x
  // byte MSB first, then the ninth bit; ack is the ninth bit read low
  task automatic xfer(input logic [7:0] d, input logic ninth, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(ninth, a);
    ack = ~a;
  endtask : xfer
endmodule : mcs_host_model
`default_nettype wire

// *** tb_mcs_top.sv ***
// self-checking bench for the module control/status block
`timescale 1ns/1ns
`default_nettype none
module tb_mcs_top;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic tx_disable = 1'b1;
  logic rx_pin = 1'b0;
  logic tx_pin = 1'b0;
  logic fault_cond = 1'b0;
  logic power_low = 1'b1;
  logic ce = 1'b1;
  logic tx_fault, los, absent, scl, sda_low, sda_o, sda_oe, laser_on, rx_eng, tx_eng;
  logic [7:0] q;
  logic ack;
  int errors = 0;
  int samples_checked = 0;
  // open-drain sda with host-board pull-up
  wire logic sda_line = ~(sda_low | (sda_oe & ~sda_o));
  always #50 mclk = ~mclk;
  mcs_host_model mcs_host_model_i (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  mcs_top mcs_top_i (
    .mclk(mclk), .rst_b(rst_b), .ce(ce), .tx_disable(tx_disable),
    .rx_retimer_select_pin(rx_pin), .tx_retimer_select_pin(tx_pin),
    .laser_fault_cond(fault_cond), .rx_power_low(power_low), .tx_fault(tx_fault),
    .rx_signal_lost_flag(los), .module_absent_flag(absent), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .tx_laser_on(laser_on), .rx_retimer_engaged(rx_eng),
    .tx_retimer_engaged(tx_eng)
  );
  task automatic end_of_test();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk1(input logic got, input logic exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %b", $time, m, got);
    end
  endtask : chk1
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %h", $time, m, got);
    end
  endtask : chk8
  task automatic cyc(input int n);
    mcs_host_model_i.wt(n);
  endtask : cyc
  task automatic wr_reg(input logic [7:0] offs, input logic [7:0] d);
    mcs_host_model_i.start();
    mcs_host_model_i.xfer(8'ha2, 1'b1, q, ack);
    chk1(ack, 1'b1, "write address ack");
    mcs_host_model_i.xfer(offs, 1'b1, q, ack);
    chk1(ack, 1'b1, "offset ack");
    mcs_host_model_i.xfer(d, 1'b1, q, ack);
    chk1(ack, 1'b1, "data ack");
    mcs_host_model_i.stop();
    cyc(3);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] offs, input logic [7:0] exp);
    mcs_host_model_i.start();
    mcs_host_model_i.xfer(8'ha2, 1'b1, q, ack);
    mcs_host_model_i.xfer(offs, 1'b1, q, ack);
    mcs_host_model_i.start();
    mcs_host_model_i.xfer(8'ha3, 1'b1, q, ack);
    chk1(ack, 1'b1, "read address ack");
    mcs_host_model_i.xfer(8'hff, 1'b1, q, ack);
    chk8(q, exp, "read data");
    mcs_host_model_i.stop();
  endtask : rd_reg
  task automatic t_reset();
    chk1(tx_fault, 1'b0, "fault in reset");
    chk1(los, 1'b1, "los in reset");
    chk1(absent, 1'b0, "module absent");
    chk1(rx_eng | tx_eng, 1'b0, "retimers default");
    rst_b = 1'b1;
    cyc(2);
    chk1(los, 1'b1, "los held after reset");
    cyc(2);
    chk1(laser_on, 1'b0, "laser with disable high");
  endtask : t_reset
  task automatic t_pins();
    for (int i = 0; i < 4; i++) begin
      {rx_pin, tx_pin} = i[1:0];
      cyc(3);
      chk1(rx_eng, i[1], "rx hard select");
      chk1(tx_eng, i[0], "tx hard select");
    end
    {rx_pin, tx_pin} = 2'b00;
    cyc(3);
  endtask : t_pins
  task automatic t_soft();
    wr_reg(mcs_pkg::MCS_RX_SOFT_OFF, 8'h08);
    chk1(rx_eng, 1'b1, "rx soft engage");
    chk1(tx_eng, 1'b0, "tx untouched");
    rd_reg(mcs_pkg::MCS_RX_SOFT_OFF, 8'h08);
    wr_reg(mcs_pkg::MCS_TX_SOFT_OFF, 8'h08);
    chk1(tx_eng, 1'b1, "tx soft engage");
    // only bit 3 selects; the other bits read back as zero
    wr_reg(mcs_pkg::MCS_RX_SOFT_OFF, 8'hf7);
    chk1(rx_eng, 1'b0, "rx soft bypass");
    rd_reg(mcs_pkg::MCS_RX_SOFT_OFF, 8'h00);
    rd_reg(8'h10, 8'h00);
    mcs_host_model_i.start();
    mcs_host_model_i.xfer(8'ha4, 1'b1, q, ack);
    chk1(ack, 1'b0, "foreign address refused");
    mcs_host_model_i.stop();
  endtask : t_soft
  // reset in mid-run must drop the soft select bits again
  task automatic t_rerst();
    chk1(tx_eng, 1'b1, "tx soft before reset");
    rst_b = 1'b0;
    cyc(2);
    chk1(tx_eng, 1'b0, "tx soft after reset");
    rst_b = 1'b1;
    cyc(4);
    rd_reg(mcs_pkg::MCS_TX_SOFT_OFF, 8'h00);
  endtask : t_rerst
  task automatic t_laser();
    tx_disable = 1'b0;
    cyc(3);
    chk1(laser_on, 1'b1, "laser enabled");
    tx_disable = 1'b1;
    cyc(3);
    chk1(laser_on, 1'b0, "laser disabled");
  endtask : t_laser
  task automatic pulse_disable();
    tx_disable = 1'b1;
    cyc(4);
    tx_disable = 1'b0;
    cyc(4);
  endtask : pulse_disable
  task automatic t_fault();
    tx_disable = 1'b0;
    fault_cond = 1'b1;
    cyc(4);
    chk1(tx_fault, 1'b1, "fault raised");
    fault_cond = 1'b0;
    cyc(4);
    chk1(tx_fault, 1'b1, "fault latched");
    fault_cond = 1'b1;
    pulse_disable();
    chk1(tx_fault, 1'b1, "clear with fault present");
    fault_cond = 1'b0;
    pulse_disable();
    chk1(tx_fault, 1'b0, "fault cleared");
  endtask : t_fault
  task automatic t_los();
    power_low = 1'b0;
    cyc(4);
    chk1(los, 1'b0, "signal present");
    ce = 1'b0;
    power_low = 1'b1;
    cyc(4);
    chk1(los, 1'b0, "flag frozen while ce low");
    ce = 1'b1;
    cyc(4);
    chk1(los, 1'b1, "signal lost");
  endtask : t_los
  initial begin
    cyc(4);
    t_reset();
    t_pins();
    t_soft();
    t_rerst();
    t_laser();
    t_fault();
    t_los();
    end_of_test();
  end
  // watchdog for a hung sequence
  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    end_of_test();
  end
endmodule : tb_mcs_top
`default_nettype wire
